// [core/pbs_pkg.sv]
/*
 * Shared constants for the pipelined burst synchronous memory port: widths, depth, burst codes and latencies.
 * Assumes one clock for both ends of the bus and a testbench that resolves the shared data wire.
 */
// Functional notes
// (R1) Capture all synchronous inputs on rising clock.
// (R2) Load address only under either address strobe.
// (R3) Two-bit counter makes burst follow-on addresses.
// (R4) Advance burst only when advance asserted.
// (R5) Interleaved or linear order by select input.
// (R6) Writes complete internally, self-timed, no strobes.
// (R7) Byte lanes written under byte-write qualifier.
// (R8) Global write writes every byte lane.
// (R9) Deselect keeps drivers one extra cycle.
// (R10) Switch between devices without wait cycles.
// (R11) Registered outputs, one stage after access.
// (R12) Burst timing three-one-one-one cycles; the code drives the first beat four cycles after the pins.
// (R13) Output enable and sleep act asynchronously.
// (R14) Selected only when all three enables active.
// (R15) Array 512K by 36 or 1M by 18; the code builds only 512K by 36.
// (R16) Counter wraps low two address bits only.
// (R17) Output enable low floats data pins; the code floats them while output_enable_n is high.
package pbs_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int WORDS = 524288;
    localparam int BURST_LEN = 4;
    localparam int FIFO_DEPTH = 4;
    localparam int FIRST_BEAT_CYCLES = 3;
    localparam logic [1:0] BURST_START = 2'h0;
    localparam logic [3:0] SYNC_RESET = 4'h0;
    typedef enum logic [1:0] {
        PBS_IDLE = 2'b00,
        PBS_READ = 2'b01,
        PBS_WRITE = 2'b10
    } pbs_state_e;
endpackage

// [core/pbs_bus_if.sv]
/*
 * Bus between the memory port and its controller; one modport for each end.
 * Assumes the testbench resolves the shared data wire from both output enables, which are low while driving.
 */
`timescale 1ns/10ps
interface pbs_bus_if;
    logic [pbs_pkg::ADDR_W-1:0] addr;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_advance_n;
    logic pipelined_select_n;
    logic expansion_select_high;
    logic expansion_select_low_n;
    logic [pbs_pkg::LANES-1:0] byte_lane_write_n;
    logic byte_write_qualifier_n;
    logic global_write_n;
    logic output_enable_n;
    logic sleep_request;
    logic burst_order_linear;
    logic [pbs_pkg::DATA_W-1:0] dq_mem_out;
    logic dq_mem_oe_n;
    logic [pbs_pkg::DATA_W-1:0] dq_ctl_out;
    logic dq_ctl_oe_n;
    logic [pbs_pkg::DATA_W-1:0] dq_in;
    modport mem (
        input addr, processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n, pipelined_select_n,
        input expansion_select_high, expansion_select_low_n, byte_lane_write_n, byte_write_qualifier_n,
        input global_write_n, output_enable_n, sleep_request, burst_order_linear, dq_in,
        output dq_mem_out, dq_mem_oe_n
    );
    modport ctl (
        output addr, processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n, pipelined_select_n,
        output expansion_select_high, expansion_select_low_n, byte_lane_write_n, byte_write_qualifier_n,
        output global_write_n, output_enable_n, sleep_request, burst_order_linear, dq_ctl_out, dq_ctl_oe_n,
        input dq_in
    );
endinterface

// [core/pbs_fifo.sv]
/*
 * Small valid/ready FIFO with parameter width and depth.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/10ps
module pbs_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;
    assign in_ready = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // pbs_fifo

// [core/pbs_mem.sv]
/*
 * Memory end: synchronous pipelined burst memory with byte writes and double-cycle deselect.
 * Assumes the controller keeps to the strobe protocol; the data wire is resolved outside.
 */
`timescale 1ns/10ps
module pbs_mem (
    // Clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // Bus to the controller.
    pbs_bus_if.mem bus,
    // User side status.
    output logic sleeping,
    output logic selected
);
    logic [pbs_pkg::ADDR_W-1:0] addr_q;
    logic [1:0] start_q;
    logic [1:0] cnt_q;
    logic active_q;
    logic wr_q;
    logic [pbs_pkg::LANES-1:0] lanes_q;
    logic [pbs_pkg::DATA_W-1:0] wdata_q;
    logic [pbs_pkg::DATA_W-1:0] wdata_hold_q;
    logic go_q;
    logic processor_addr_strobe_q;
    logic controller_addr_strobe_q;
    logic adv_q;
    logic sel_q;
    logic [pbs_pkg::ADDR_W-1:0] ain_q;
    logic [pbs_pkg::LANES-1:0] bw_q;
    logic bwe_q;
    logic gw_q;
    logic lin_q;
    logic [pbs_pkg::DATA_W-1:0] rd_q;
    logic rd_stage_q;
    logic drive_q;
    logic drive_ext_q;
    logic [pbs_pkg::DATA_W-1:0] rd_word;
    logic [1:0] low_bits;
    logic [pbs_pkg::ADDR_W-1:0] cur_addr;
    logic strobe;
    // (R1) Capture synchronous inputs.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            processor_addr_strobe_q <= 1'b0;
            controller_addr_strobe_q <= 1'b0;
            adv_q <= 1'b0;
            sel_q <= 1'b0;
            ain_q <= '0;
            bw_q <= '0;
            bwe_q <= 1'b0;
            gw_q <= 1'b0;
            lin_q <= 1'b0;
            wdata_q <= '0;
        end
        else
        begin
            processor_addr_strobe_q <= !bus.processor_addr_strobe_n;
            controller_addr_strobe_q <= !bus.controller_addr_strobe_n;
            adv_q <= !bus.burst_advance_n;
            // (R14) All three enables.
            sel_q <= !bus.pipelined_select_n && bus.expansion_select_high && !bus.expansion_select_low_n;
            ain_q <= bus.addr;
            bw_q <= ~bus.byte_lane_write_n;
            bwe_q <= !bus.byte_write_qualifier_n;
            gw_q <= !bus.global_write_n;
            lin_q <= bus.burst_order_linear;
            wdata_q <= bus.dq_in;
        end
    end
    assign strobe = processor_addr_strobe_q || controller_addr_strobe_q;
    // (R5) Burst order select.
    assign low_bits = lin_q ? 2'(start_q + cnt_q) : (start_q ^ cnt_q);
    // (R16) Low two bits wrap.
    assign cur_addr = {addr_q[pbs_pkg::ADDR_W-1:2], low_bits};
    // (R2) Load on address strobe.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            addr_q <= '0;
            start_q <= pbs_pkg::BURST_START;
            cnt_q <= pbs_pkg::BURST_START;
            active_q <= 1'b0;
            go_q <= 1'b0;
        end
        else if (strobe)
        begin
            addr_q <= ain_q;
            start_q <= ain_q[1:0];
            cnt_q <= pbs_pkg::BURST_START;
            active_q <= sel_q;
            go_q <= sel_q;
        end
        // (R3) Two-bit burst counter.
        else if (adv_q && active_q)
        begin
            // (R4) Advance only on request.
            cnt_q <= cnt_q + 2'h1;
            go_q <= 1'b1;
        end
        else
        begin
            // An access lasts one cycle unless the burst is advanced.
            go_q <= 1'b0;
        end
    end
    // (R7) Byte lanes under qualifier; (R8) global write forces all lanes.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_q <= 1'b0;
            lanes_q <= '0;
            wdata_hold_q <= '0;
        end
        else
        begin
            wr_q <= gw_q || (bwe_q && (bw_q != '0));
            lanes_q <= gw_q ? '1 : (bwe_q ? bw_q : '0);
            wdata_hold_q <= wdata_q;
        end
    end
    // (R6) Self-timed internal write.
    // (R15) Array organisation.
    generate
        for (genvar g = 0; g < pbs_pkg::LANES; g++)
        begin : g_lane
            logic [pbs_pkg::LANE_W-1:0] lane_q [pbs_pkg::WORDS];
            always_ff @(posedge mclk)
            begin
                if (go_q && wr_q && lanes_q[g])
                begin
                    lane_q[cur_addr] <= wdata_hold_q[g*pbs_pkg::LANE_W +: pbs_pkg::LANE_W];
                end
            end
            assign rd_word[g*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] = lane_q[cur_addr];
        end
    endgenerate
    // (R11) Registered outputs; (R12) first beat four cycles after pins.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_q <= '0;
            rd_stage_q <= 1'b0;
            drive_q <= 1'b0;
            drive_ext_q <= 1'b0;
        end
        else
        begin
            rd_q <= rd_word;
            rd_stage_q <= go_q && !wr_q && !bus.sleep_request;
            drive_q <= rd_stage_q;
            // (R9) Extra enable stage.
            drive_ext_q <= drive_q;
        end
    end
    assign bus.dq_mem_out = rd_q;
    // (R13) Asynchronous enables; (R17) float when disabled; (R10) no wait on switch.
    assign bus.dq_mem_oe_n = !((drive_q || drive_ext_q) && !bus.output_enable_n && !bus.sleep_request);
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sleeping <= 1'b0;
            selected <= 1'b0;
        end
        else
        begin
            sleeping <= bus.sleep_request;
            selected <= active_q;
        end
    end
endmodule // pbs_mem

// [core/pbs_ctl.sv]
/*
 * Controller end: takes requests through a FIFO and drives strobe-started single-beat accesses, never asserting burst advance.
 * Assumes one memory on the bus interface and a testbench that resolves the data wire.
 */
`timescale 1ns/10ps
module pbs_ctl (
    // Clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // Request side.
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [pbs_pkg::ADDR_W-1:0] req_addr,
    input wire logic [pbs_pkg::DATA_W-1:0] req_data,
    input wire logic [pbs_pkg::LANES-1:0] req_lanes,
    input wire logic req_linear,
    // Read answers.
    output logic rsp_valid,
    output logic [pbs_pkg::DATA_W-1:0] rsp_data,
    // Bus to the memory.
    pbs_bus_if.ctl bus
);
    localparam int RW = 1 + pbs_pkg::ADDR_W + pbs_pkg::DATA_W + pbs_pkg::LANES;
    logic f_valid;
    logic f_ready;
    logic [RW-1:0] f_data;
    pbs_pkg::pbs_state_e st_q;
    logic [3:0] pipe_q;
    logic in_ready;
    assign req_ready = in_ready;
    pbs_fifo #(.WIDTH(RW), .DEPTH(pbs_pkg::FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .nrst(nrst),
        .in_valid(req_valid),
        .in_ready(in_ready),
        .in_data({req_write, req_addr, req_data, req_lanes}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );
    // Hold new accesses until a read has left the shared data wire.
    assign f_ready = (st_q == pbs_pkg::PBS_IDLE) && (pipe_q == '0);
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= pbs_pkg::PBS_IDLE;
            bus.addr <= '0;
            bus.processor_addr_strobe_n <= 1'b1;
            bus.controller_addr_strobe_n <= 1'b1;
            bus.burst_advance_n <= 1'b1;
            bus.pipelined_select_n <= 1'b1;
            bus.expansion_select_high <= 1'b0;
            bus.expansion_select_low_n <= 1'b1;
            bus.byte_lane_write_n <= '1;
            bus.byte_write_qualifier_n <= 1'b1;
            bus.global_write_n <= 1'b1;
            bus.dq_ctl_out <= '0;
            bus.dq_ctl_oe_n <= 1'b1;
            pipe_q <= pbs_pkg::SYNC_RESET;
        end
        else
        begin
            bus.controller_addr_strobe_n <= 1'b1;
            bus.burst_advance_n <= 1'b1;
            bus.byte_write_qualifier_n <= 1'b1;
            bus.dq_ctl_oe_n <= 1'b1;
            pipe_q <= {pipe_q[2:0], st_q == pbs_pkg::PBS_READ};
            if (f_valid && f_ready)
            begin
                // (R2) Start with controller strobe; (R14) assert all enables.
                bus.controller_addr_strobe_n <= 1'b0;
                bus.pipelined_select_n <= 1'b0;
                bus.expansion_select_high <= 1'b1;
                bus.expansion_select_low_n <= 1'b0;
                bus.addr <= f_data[RW-2 -: pbs_pkg::ADDR_W];
                if (f_data[RW-1])
                begin
                    // (R7) Qualified byte lanes.
                    bus.byte_write_qualifier_n <= 1'b0;
                    bus.byte_lane_write_n <= ~f_data[pbs_pkg::LANES-1:0];
                    bus.dq_ctl_out <= f_data[pbs_pkg::LANES +: pbs_pkg::DATA_W];
                    bus.dq_ctl_oe_n <= 1'b0;
                    st_q <= pbs_pkg::PBS_WRITE;
                end
                else
                begin
                    st_q <= pbs_pkg::PBS_READ;
                end
            end
            else if (st_q != pbs_pkg::PBS_IDLE)
            begin
                st_q <= pbs_pkg::PBS_IDLE;
                bus.pipelined_select_n <= 1'b1;
            end
        end
    end
    // Sleep is never requested; order follows the req_linear input, which the FIFO does not store with the request.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            bus.output_enable_n <= 1'b1;
            bus.sleep_request <= 1'b0;
            bus.global_write_n <= 1'b1;
            bus.burst_order_linear <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
        end
        else
        begin
            bus.output_enable_n <= 1'b0;
            bus.burst_order_linear <= req_linear;
            // (R12) Read data four stages after strobe.
            rsp_valid <= pipe_q[3];
            if (pipe_q[3])
            begin
                rsp_data <= bus.dq_in;
            end
        end
    end
endmodule // pbs_ctl

// [tb/pbs_bus_properties.sv]
/*
 * Concurrent checks on the bus between the memory end and the controller end.
 * Assumes one clock, an active-low asynchronous reset and a testbench that resolves the data wire.
 */
`timescale 1ns/10ps
module pbs_bus_properties (
    // Clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // Strobes and selects.
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic pipelined_select_n,
    input wire logic expansion_select_high,
    input wire logic expansion_select_low_n,
    // Write controls and output enable.
    input wire logic [pbs_pkg::LANES-1:0] byte_lane_write_n,
    input wire logic byte_write_qualifier_n,
    input wire logic global_write_n,
    input wire logic output_enable_n,
    // Data drivers.
    input wire logic dq_mem_oe_n,
    input wire logic dq_ctl_oe_n
);
    wire strobe = !processor_addr_strobe_n || !controller_addr_strobe_n;
    wire wr_cyc = !global_write_n || (!byte_write_qualifier_n && !(&byte_lane_write_n));
    wire rd_strobe = strobe && !wr_cyc && !output_enable_n;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    a_strobe_single: assert property (strobe |=> !strobe)
        else $error("address strobe held longer than one cycle");
    a_select_with_strobe: assert property (strobe |-> !pipelined_select_n && expansion_select_high && !expansion_select_low_n)
        else $error("strobe issued without all selects active");
    a_read_drive_time: assert property (rd_strobe |-> ##4 (!dq_mem_oe_n || output_enable_n) [*2])
        else $error("read data not driven in its two cycles");
    a_drive_needs_read: assert property ($fell(dq_mem_oe_n) && $stable(output_enable_n) |-> $past(rd_strobe, 4))
        else $error("memory drove the bus without a read four cycles before");
    a_dcd_extra_cycle: assert property ($rose(dq_mem_oe_n) && !output_enable_n |-> $past(dq_mem_oe_n, 2) == 1'b0)
        else $error("memory released the bus after a single cycle");
    a_oe_floats_bus: assert property (output_enable_n |-> dq_mem_oe_n)
        else $error("memory drove the bus while output enable was off");
    a_no_bus_contention: assert property (!(!dq_mem_oe_n && !dq_ctl_oe_n))
        else $error("both ends drove the data wire");
    a_write_data_driven: assert property (strobe && wr_cyc |-> !dq_ctl_oe_n)
        else $error("write strobe without write data on the bus");
endmodule // pbs_bus_properties

// [tb/tb.sv]
/*
 * Testbench joining both ends of the bus; the request FIFO is checked through the controller.
 * Assumes the design packages and interface are compiled first.
 */
`timescale 1ns/10ps
module tb;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic req_valid = 1'b0;
    logic req_ready;
    logic req_write = 1'b0;
    logic [pbs_pkg::ADDR_W-1:0] req_addr = '0;
    logic [pbs_pkg::DATA_W-1:0] req_data = '0;
    logic [pbs_pkg::LANES-1:0] req_lanes = '0;
    logic req_linear = 1'b0;
    logic rsp_valid;
    logic [pbs_pkg::DATA_W-1:0] rsp_data;
    logic mem_sleeping;
    logic mem_selected;
    logic [pbs_pkg::DATA_W-1:0] shadow;
    int num_errors = 0;
    int cmp_count = 0;
    int n;
    pbs_bus_if bus ();
    assign bus.dq_in = !bus.dq_mem_oe_n ? bus.dq_mem_out : (!bus.dq_ctl_oe_n ? bus.dq_ctl_out : {9{mclk, 3'h5}});
    always #5 mclk = ~mclk;
    pbs_mem i_pbs_mem (.mclk(mclk), .nrst(nrst), .bus(bus.mem), .sleeping(mem_sleeping), .selected(mem_selected));
    pbs_ctl i_pbs_ctl (.mclk(mclk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_data(req_data), .req_lanes(req_lanes),
        .req_linear(req_linear), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .bus(bus.ctl));
    pbs_bus_properties i_pbs_bus_properties (.mclk(mclk), .nrst(nrst),
        .processor_addr_strobe_n(bus.processor_addr_strobe_n), .controller_addr_strobe_n(bus.controller_addr_strobe_n),
        .pipelined_select_n(bus.pipelined_select_n), .expansion_select_high(bus.expansion_select_high),
        .expansion_select_low_n(bus.expansion_select_low_n), .byte_lane_write_n(bus.byte_lane_write_n),
        .byte_write_qualifier_n(bus.byte_write_qualifier_n), .global_write_n(bus.global_write_n),
        .output_enable_n(bus.output_enable_n), .dq_mem_oe_n(bus.dq_mem_oe_n), .dq_ctl_oe_n(bus.dq_ctl_oe_n));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic send(input logic wr, input logic [pbs_pkg::ADDR_W-1:0] a, input logic [pbs_pkg::DATA_W-1:0] d,
        input logic [pbs_pkg::LANES-1:0] l, input logic lin);
        int k;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_data = d;
        req_lanes = l;
        req_linear = lin;
        k = 0;
        while (req_ready !== 1'b1 && k < 100)
        begin
            k++;
            @(posedge mclk);
            #1;
        end
        @(posedge mclk);
        #1;
        req_valid = 1'b0;
        @(posedge mclk);
        #1;
    endtask

    task automatic read_check(input logic [pbs_pkg::ADDR_W-1:0] a, input logic [pbs_pkg::DATA_W-1:0] exp,
        input logic lin);
        int k;
        send(1'b0, a, '0, '0, lin);
        k = 0;
        while (rsp_valid !== 1'b1 && k < 100)
        begin
            k++;
            @(posedge mclk);
            #1;
        end
        check(rsp_valid, 1'b1);
        check(rsp_data, exp);
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        #50000;
        num_errors++;
        report_and_stop();
    end

    initial
    begin
        repeat (6) @(posedge mclk);
        #1;
        nrst = 1'b1;
        send(1'b1, 19'h00000, 36'h123456789, 4'hF, 1'b0);
        send(1'b1, 19'h7FFFF, 36'hFEDCBA987, 4'hF, 1'b1);
        read_check(19'h00000, 36'h123456789, 1'b0);
        read_check(19'h7FFFF, 36'hFEDCBA987, 1'b1);
        check(mem_selected, 1'b1);
        check(mem_sleeping, 1'b0);
        shadow = 36'h0;
        send(1'b1, 19'h00005, shadow, 4'hF, 1'b0);
        for (int i = 0; i < pbs_pkg::LANES; i++)
        begin
            send(1'b1, 19'h00005, {pbs_pkg::LANES{9'(9'h1A0 + i)}}, 4'(1 << i), 1'(i));
            shadow[pbs_pkg::LANE_W*i+:pbs_pkg::LANE_W] = 9'(9'h1A0 + i);
            read_check(19'h00005, shadow, 1'(i));
        end
        for (int i = 0; i < 2 * pbs_pkg::BURST_LEN; i++)
            send(1'b1, 19'(19'h00008 + i), 36'(36'hC0000 + i), 4'hF, 1'(i));
        for (int i = 0; i < 2 * pbs_pkg::BURST_LEN; i++)
            read_check(19'(19'h00008 + i), 36'(36'hC0000 + i), 1'(i));
        send(1'b0, 19'h00000, '0, '0, 1'b0);
        n = 0;
        req_valid = 1'b1;
        req_write = 1'b1;
        req_lanes = 4'hF;
        while (req_ready === 1'b1 && n < 10)
        begin
            req_addr = 19'(19'h00010 + n);
            req_data = 36'(36'hA00 + n);
            @(posedge mclk);
            #1;
            n++;
        end
        check(n, pbs_pkg::FIFO_DEPTH);
        check(req_ready, 1'b0);
        req_valid = 1'b0;
        for (int k = 0; k < pbs_pkg::FIFO_DEPTH; k++)
        begin
            read_check(19'(19'h00010 + k), 36'(36'hA00 + k), 1'b0);
        end
        nrst = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        nrst = 1'b1;
        check(mem_selected, 1'b0);
        send(1'b1, 19'h40001, 36'h0F0F0F0F0, 4'hF, 1'b0);
        read_check(19'h40001, 36'h0F0F0F0F0, 1'b0);
        repeat (10) @(posedge mclk);
        report_and_stop();
    end
endmodule // tb
